// >>> aoe_defs.svh
`ifndef AOE_DEFS_SVH
`define AOE_DEFS_SVH

// Opcode upper bytes / prefixes
`define AOE_OP_ADD_LIT_HI   8'h0F
`define AOE_OP_OR_LIT_HI    8'h09
`define AOE_OP_ADD_FILE_PFX 6'h09
`define AOE_OP_OR_FILE_PFX  6'h04
// Field positions
`define AOE_BIT_DEST      9
`define AOE_BIT_BANK      8
// Indexed literal-offset ceiling
`define AOE_IDX_MAX       8'h5F
// Status flag positions
`define AOE_FLG_C         0
`define AOE_FLG_NIB       1
`define AOE_FLG_Z         2
`define AOE_FLG_EXC       3
`define AOE_FLG_N         4
// Reset values
`define AOE_W_RST         8'h00
`define AOE_STAT_RST      5'h00

`endif

// >>> aoe_pkg.sv
`default_nettype none
package aoe_pkg;
  typedef enum logic [3:0] {
    AOE_Q1 = 4'h1,
    AOE_Q2 = 4'h2,
    AOE_Q3 = 4'h4,
    AOE_Q4 = 4'h8
  } aoe_phase_t;
  typedef enum logic [2:0] {
    AOE_OP_NONE = 3'h0,
    AOE_OP_ADDL = 3'h1,
    AOE_OP_ADDF = 3'h2,
    AOE_OP_IORL = 3'h3,
    AOE_OP_IORF = 3'h4
  } aoe_op_t;
endpackage
`default_nettype wire

// >>> aoe_file_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Small file register memory, registered read
// ----------------------------------------
module aoe_file_mem #(
  parameter int AW = 12
) (
  input  wire logic          clk_sys,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data
);
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] rd_d;

  // Read mux
  always_comb begin
    rd_d = mem[rd_addr];
  end

  // Storage and read register
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= rd_d;
  end
endmodule
`default_nettype wire

// >>> aoe_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "aoe_defs.svh"
module aoe_core #(
  parameter int          AW        = 12,
  parameter logic [7:0]  ACC_SPLIT = 8'h60
) (
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  input  wire logic          instr_valid,
  input  wire logic [15:0]   instr_word,
  input  wire logic          ext_set_en,
  input  wire logic [3:0]    bank_pointer_reg,
  input  wire logic [AW-1:0] index_base,
  output logic               instr_ready,
  output logic               instr_done,
  output logic               instr_illegal,
  output logic [7:0]         work_reg,
  output logic [4:0]         status_flags,
  output logic [AW-1:0]      file_addr
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  aoe_pkg::aoe_phase_t phase_q, phase_d;
  aoe_pkg::aoe_op_t    op_q, op_d;
  logic [15:0]   ir_q, ir_d;
  logic [7:0]    w_q, w_d;
  logic [4:0]    st_q, st_d;
  logic [7:0]    opnd_q, opnd_d;
  logic [7:0]    res_q, res_d;
  logic [AW-1:0] addr_q, addr_d;
  logic          done_q, done_d;
  logic          ill_q, ill_d;
  logic [7:0]    mem_rd;
  logic          mem_we;
  logic [8:0]    sum9;
  logic [4:0]    sum_lo;
  logic          dest_file;

  assign dest_file = ir_q[`AOE_BIT_DEST];

  // ----------------------------------------
  // File register storage
  // ----------------------------------------
  aoe_file_mem #(.AW(AW)) u_mem (
    .clk_sys (clk_sys),
    .rd_addr (addr_q),
    .rd_data (mem_rd),
    .wr_en   (mem_we),
    .wr_addr (addr_q),
    .wr_data (res_d)  // Result of this write phase, not the previous one
  );

  // Write back only for file ops with d=1
  assign mem_we = (phase_q == aoe_pkg::AOE_Q4) && dest_file
                  && ((op_q == aoe_pkg::AOE_OP_ADDF) || (op_q == aoe_pkg::AOE_OP_IORF));

  // Adder pieces
  assign sum9   = {1'b0, w_q} + {1'b0, opnd_q};
  assign sum_lo = {1'b0, w_q[3:0]} + {1'b0, opnd_q[3:0]};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    phase_d = phase_q;
    op_d    = op_q;
    ir_d    = ir_q;
    w_d     = w_q;
    st_d    = st_q;
    opnd_d  = opnd_q;
    res_d   = res_q;
    addr_d  = addr_q;
    done_d  = 1'b0;
    ill_d   = 1'b0;
    case (phase_q)
      aoe_pkg::AOE_Q1: begin
        // Decode
        if (instr_valid) begin
          ir_d    = instr_word;
          phase_d = aoe_pkg::AOE_Q2;
          if (instr_word[15:8] == `AOE_OP_ADD_LIT_HI) begin
            op_d = aoe_pkg::AOE_OP_ADDL;
          end else if (instr_word[15:8] == `AOE_OP_OR_LIT_HI) begin
            op_d = aoe_pkg::AOE_OP_IORL;
          end else if (instr_word[15:10] == `AOE_OP_ADD_FILE_PFX) begin
            op_d = aoe_pkg::AOE_OP_ADDF;
          end else if (instr_word[15:10] == `AOE_OP_OR_FILE_PFX) begin
            op_d = aoe_pkg::AOE_OP_IORF;
          end else begin
            op_d    = aoe_pkg::AOE_OP_NONE;
            phase_d = aoe_pkg::AOE_Q1;
            ill_d   = 1'b1;
          end
          // Operand address
          if (instr_word[`AOE_BIT_BANK]) begin
            addr_d = AW'({bank_pointer_reg, instr_word[7:0]});
          end else if (ext_set_en && (instr_word[7:0] <= `AOE_IDX_MAX)) begin
            addr_d = index_base + AW'(instr_word[7:0]);
          end else if (instr_word[7:0] < ACC_SPLIT) begin
            addr_d = AW'(instr_word[7:0]);
          end else begin
            addr_d = AW'({4'hF, instr_word[7:0]});
          end
        end
      end
      aoe_pkg::AOE_Q2: begin
        // Read operand: literal now, file word arrives next phase
        opnd_d  = ir_q[7:0];
        phase_d = aoe_pkg::AOE_Q3;
      end
      aoe_pkg::AOE_Q3: begin
        // Process data
        if ((op_q == aoe_pkg::AOE_OP_ADDF) || (op_q == aoe_pkg::AOE_OP_IORF)) begin
          opnd_d = mem_rd;
        end
        phase_d = aoe_pkg::AOE_Q4;
      end
      aoe_pkg::AOE_Q4: begin
        // Write destination and flags
        phase_d = aoe_pkg::AOE_Q1;
        done_d  = 1'b1;
        if ((op_q == aoe_pkg::AOE_OP_ADDL) || (op_q == aoe_pkg::AOE_OP_ADDF)) begin
          res_d = sum9[7:0];
          st_d[`AOE_FLG_C]  = sum9[8];
          st_d[`AOE_FLG_NIB] = sum_lo[4];
          st_d[`AOE_FLG_EXC] = (w_q[7] == opnd_q[7]) && (sum9[7] != w_q[7]);
          st_d[`AOE_FLG_Z]  = (sum9[7:0] == 8'h00);
          st_d[`AOE_FLG_N]  = sum9[7];
        end else begin
          res_d = w_q | opnd_q;
          st_d[`AOE_FLG_Z] = ((w_q | opnd_q) == 8'h00);
          st_d[`AOE_FLG_N] = w_q[7] | opnd_q[7];
        end
        if (!(((op_q == aoe_pkg::AOE_OP_ADDF) || (op_q == aoe_pkg::AOE_OP_IORF)) && dest_file)) begin
          w_d = res_d;
        end
      end
      default: begin
        phase_d = aoe_pkg::AOE_Q1;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= aoe_pkg::AOE_Q1;
      op_q    <= aoe_pkg::AOE_OP_NONE;
      ir_q    <= 16'h0000;
      w_q     <= `AOE_W_RST;
      st_q    <= `AOE_STAT_RST;
      opnd_q  <= 8'h00;
      res_q   <= 8'h00;
      addr_q  <= '0;
      done_q  <= 1'b0;
      ill_q   <= 1'b0;
    end else begin
      phase_q <= phase_d;
      op_q    <= op_d;
      ir_q    <= ir_d;
      w_q     <= w_d;
      st_q    <= st_d;
      opnd_q  <= opnd_d;
      res_q   <= res_d;
      addr_q  <= addr_d;
      done_q  <= done_d;
      ill_q   <= ill_d;
    end
  end

  // Outputs
  assign instr_ready   = (phase_q == aoe_pkg::AOE_Q1);
  assign instr_done    = done_q;
  assign instr_illegal = ill_q;
  assign work_reg      = w_q;
  assign status_flags  = st_q;
  assign file_addr     = addr_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_four_phase_cycle: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (phase_q == aoe_pkg::AOE_Q1 && phase_d == aoe_pkg::AOE_Q2) |=> ##3 done_q)
    else $error("instruction did not finish in four phases");
  a_add_lit_sum: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (instr_ready && instr_valid && instr_word[15:8] == 8'h0F)
    |=> ##3 (w_q == 8'($past(w_q, 4) + $past(instr_word[7:0], 4))))
    else $error("literal add result wrong");
  a_or_lit_result: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (instr_ready && instr_valid && instr_word[15:8] == 8'h09)
    |=> ##3 (w_q == ($past(w_q, 4) | $past(instr_word[7:0], 4))))
    else $error("literal or result wrong");
  a_or_keeps_carry: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (phase_q == aoe_pkg::AOE_Q4 && (op_q == aoe_pkg::AOE_OP_IORL || op_q == aoe_pkg::AOE_OP_IORF))
    |=> (st_q[0] == $past(st_q[0]) && st_q[1] == $past(st_q[1]) && st_q[3] == $past(st_q[3])))
    else $error("or changed arithmetic flags");
  a_add_zero_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (done_q && (op_q == aoe_pkg::AOE_OP_ADDL || op_q == aoe_pkg::AOE_OP_ADDF))
    |-> (st_q[2] == (res_q == 8'h00)) && (st_q[4] == res_q[7]))
    else $error("add zero or negative flag wrong");
  a_dest_file_keeps_w: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (phase_q == aoe_pkg::AOE_Q4 && op_q == aoe_pkg::AOE_OP_ADDF && dest_file) |=> $stable(w_q))
    else $error("working register changed on file destination");
  a_file_add_decode: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (instr_ready && instr_valid && instr_word[15:10] == 6'h09) |=> op_q == aoe_pkg::AOE_OP_ADDF)
    else $error("file add not decoded");
  a_file_or_decode: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (instr_ready && instr_valid && instr_word[15:10] == 6'h04) |=> op_q == aoe_pkg::AOE_OP_IORF)
    else $error("file or not decoded");
  a_bank_select: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (instr_ready && instr_valid && instr_word[8]) |=> addr_q == AW'({$past(bank_pointer_reg), ir_q[7:0]}))
    else $error("banked address wrong");
  a_indexed_addr: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (instr_ready && instr_valid && ext_set_en && !instr_word[8] && instr_word[7:0] <= 8'h5F)
    |=> addr_q == AW'($past(index_base) + AW'(ir_q[7:0])))
    else $error("indexed address wrong");
  c_add_literal: cover property (@(posedge clk_sys) done_q && op_q == aoe_pkg::AOE_OP_ADDL);
  c_add_file_back: cover property (@(posedge clk_sys) done_q && op_q == aoe_pkg::AOE_OP_ADDF && dest_file);
  c_or_file_w: cover property (@(posedge clk_sys) done_q && op_q == aoe_pkg::AOE_OP_IORF && !dest_file);
  c_add_carry: cover property (@(posedge clk_sys) done_q && st_q[0]);
endmodule
`default_nettype wire

// >>> add_or_instruction_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module add_or_instruction_exec_tb;
  localparam int AW = 12;
  logic          clk_sys;
  logic          arst_n;
  logic          instr_valid;
  logic [15:0]   instr_word;
  logic          ext_set_en;
  logic [3:0]    bank_pointer_reg;
  logic [AW-1:0] index_base;
  logic          instr_ready;
  logic          instr_done;
  logic          instr_illegal;
  logic [7:0]    work_reg;
  logic [4:0]    status_flags;
  logic [AW-1:0] file_addr;
  logic [AW-1:0] addr_seen;
  int            error_cnt;
  int            checks;
  int            lat;
  int            n;

  aoe_core #(.AW(AW)) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .ext_set_en(ext_set_en), .bank_pointer_reg(bank_pointer_reg), .index_base(index_base),
    .instr_ready(instr_ready), .instr_done(instr_done), .instr_illegal(instr_illegal),
    .work_reg(work_reg), .status_flags(status_flags), .file_addr(file_addr));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // One instruction, waits for completion, records address after decode
  task automatic run(input logic [15:0] w);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word  <= w;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    lat = 0;
    repeat (6) begin
      @(posedge clk_sys);
      #1;
      lat++;
      if (lat == 1) addr_seen = file_addr;
      if (instr_done === 1'b1) break;
    end
    check(lat == 3, "completion latency");
  endtask

  task automatic lit_step(input logic [15:0] w, input logic [7:0] ew, input logic [4:0] ef);
    run(w);
    check(work_reg === ew, "literal result");
    check(status_flags === ef, "literal flags");
  endtask

  // File operand op: address after decode, working register and flags after completion
  task automatic file_step(input logic ext, input logic [15:0] w, input logic [AW-1:0] ea,
                           input logic [7:0] ew, input logic [4:0] ef);
    @(posedge clk_sys);
    ext_set_en <= ext;
    run(w);
    check(addr_seen === ea, "operand address");
    check(work_reg === ew, "working register after file op");
    check(status_flags === ef, "file op flags");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check(instr_ready === 1'b1 && instr_done === 1'b0 && instr_illegal === 1'b0, "reset strobes");
    check(work_reg === 8'h00 && status_flags === 5'h00 && file_addr === 12'h000, "reset values");
    $display("test reset done");
  endtask

  task automatic t_add_lit();
    lit_step(16'h0F8F, 8'h8F, 5'h10);
    lit_step(16'h0F71, 8'h00, 5'h07);
    lit_step(16'h0F7F, 8'h7F, 5'h00);
    lit_step(16'h0F01, 8'h80, 5'h1A);
    $display("test add literal done");
  endtask

  task automatic t_or_lit();
    lit_step(16'h0F80, 8'h00, 5'h0D);
    lit_step(16'h0900, 8'h00, 5'h0D);
    lit_step(16'h099A, 8'h9A, 5'h19);
    lit_step(16'h0935, 8'hBF, 5'h19);
    $display("test or literal done");
  endtask

  // Request held high: only taken again when the cycle completes
  task automatic t_back2back();
    n = 0;
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word  <= 16'h0F01;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_sys);
      if (i == 7) instr_valid <= 1'b0;
      #1;
      if (instr_done === 1'b1) n++;
    end
    check(n == 2, "back to back count");
    check(work_reg === 8'hC1 && status_flags === 5'h10, "back to back result");
    $display("test back to back done");
  endtask

  task automatic t_illegal();
    logic [7:0] w0;
    w0 = work_reg;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      instr_valid <= 1'b1;
      instr_word  <= (i == 0) ? 16'hFFFF : 16'h2800;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      #1;
      check(instr_illegal === 1'b1 && instr_ready === 1'b1, "illegal pulse");
      @(posedge clk_sys);
      #1;
      check(instr_illegal === 1'b0 && instr_done === 1'b0 && work_reg === w0, "illegal no effect");
    end
    $display("test illegal done");
  endtask

  // Working register all ones makes every OR write-back a known FF into memory
  task automatic t_file();
    lit_step(16'h0F3E, 8'hFF, 5'h10);
    file_step(1'b0, 16'h125F, 12'h05F, 8'hFF, 5'h10);
    file_step(1'b0, 16'h1260, 12'hF60, 8'hFF, 5'h10);
    file_step(1'b0, 16'h1334, 12'hA34, 8'hFF, 5'h10);
    file_step(1'b1, 16'h125F, 12'h35F, 8'hFF, 5'h10);
    file_step(1'b1, 16'h1260, 12'hF60, 8'hFF, 5'h10);
    file_step(1'b1, 16'h1310, 12'hA10, 8'hFF, 5'h10);
    file_step(1'b1, 16'h1200, 12'h300, 8'hFF, 5'h10);
    file_step(1'b1, 16'h2600, 12'h300, 8'hFF, 5'h13);
    file_step(1'b0, 16'h2734, 12'hA34, 8'hFF, 5'h13);
    file_step(1'b0, 16'h1205, 12'h005, 8'hFF, 5'h13);
    file_step(1'b0, 16'h2405, 12'h005, 8'hFE, 5'h13);
    lit_step(16'h0F03, 8'h01, 5'h03);
    file_step(1'b0, 16'h2605, 12'h005, 8'h01, 5'h07);
    file_step(1'b0, 16'h2405, 12'h005, 8'h01, 5'h00);
    file_step(1'b0, 16'h105F, 12'h05F, 8'hFF, 5'h10);
    $display("test file operand done");
  endtask

  task automatic summarize();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    arst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    ext_set_en = 1'b0;
    bank_pointer_reg = 4'hA;
    index_base = 12'h300;
    error_cnt = 0;
    checks = 0;
    repeat (8) @(posedge clk_sys);
    #1;
    t_reset();
    @(posedge clk_sys);
    arst_n <= 1'b1;
    t_add_lit();
    t_or_lit();
    t_back2back();
    t_illegal();
    t_file();
    summarize();
  end

  initial begin
    #20000;
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
